// ### hw/mcu8_core.v
// 8-bit microcontroller core with apb control and status access
//
// Behaviour
// - add with or without carry, and, or, xor immediate, ram or register
// - exchange low nibble with ram byte; swap accumulator nibbles
// - decimal adjust corrects a binary sum of two packed bcd bytes
// - inc, dec, clear, complement; rotate one bit with or without carry
// - all ram reachable via either pointer; indirect bytes incrementable
// - carry and aux carry set on overflow, kept in status word, stacked
// - two user flags clear, complement, jump tests; flag a in status word
// - two-byte jump within 2K bank; other bank after a bank select
// - bank select leaves pc alone; applies at every later two-byte jump or call
// - return goes to calling bank; bank selection itself is unchanged
// - conditional jumps test live pins, accumulator, flags; page target
// - decrement working register, branch within page when result nonzero
// - indirect jump reads page byte at accumulator into pc low byte
// - timer loaded and read anytime; timer or counter start; one stop
// - interrupt enables; external off at reset, masked during service
// - register bank switches at once; restoring return restores the bank
// - divide-by-three clock on test pin a, cleared only by reset
// - ports latch outputs, read pins, and/or immediate; set 1 to read
// - bus lines move as one; strobed external moves, else high impedance unless written as output
// - port 2 low nibble is expander bus; expander and/or use accumulator
// - bus written as output stays output until reset or external move
`include "mcu8_core_regs.vh"

module mcu8_core (
	input  wire        pclk,
	input  wire        presetn,
	input  wire [7:0]  paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg  [11:0] prog_addr,
	input  wire [7:0]  prog_data,
	input  wire        test_input_a,
	input  wire        test_input_b,
	input  wire        ext_irq_n,
	output reg         test_a_clk_out,
	output reg         test_a_clk_oe,
	input  wire [7:0]  p1_in,
	output reg  [7:0]  p1_out,
	output reg  [7:0]  p1_oe,
	input  wire [7:0]  p2_in,
	output reg  [7:0]  p2_out,
	output reg  [7:0]  p2_oe,
	input  wire [7:0]  bus_in,
	output reg  [7:0]  bus_out,
	output reg         bus_oe,
	output reg         bus_ale,
	output reg         bus_rd_n,
	output reg         bus_wr_n,
	output reg         exp_strobe_n
);

// ----------------------------------------------------------------------
// state codes and helpers
// ----------------------------------------------------------------------
localparam S_FETCH = 9'h001;
localparam S_OP    = 9'h002;
localparam S_ARG   = 9'h004;
localparam S_EXEC  = 9'h008;
localparam S_TBL   = 9'h010;
localparam S_EXT1  = 9'h020;
localparam S_EXT2  = 9'h040;
localparam S_XP1   = 9'h080;
localparam S_XP2   = 9'h100;

function [5:0] wreg;
	input       bank;
	input [2:0] r;
	begin
		wreg = bank ? (`BANK1_BASE + {3'h0, r}) : {3'h0, r};
	end
endfunction

function [11:0] inc_pc;
	input [11:0] p;
	begin
		inc_pc = {p[11], p[10:0] + 11'h001};
	end
endfunction

function two_byte;
	input [7:0] o;
	begin
		two_byte = (o[7:4] >= `G_ADD && o[7:4] <= `G_MOVA &&
			o[3:0] == `SRC_IMM) || o[7:4] == `G_JMP ||
			o[7:4] == `G_DJNZ || o[7:4] == `G_JCND ||
			(o[7:4] == `G_XCH && o[3:2] == 2'h3);
	end
endfunction

// ----------------------------------------------------------------------
// core state
// ----------------------------------------------------------------------
reg [8:0]  state;
reg [7:0]  op;
reg [7:0]  arg;
reg [7:0]  acc;
reg [11:0] pc;
reg        cy;
reg        ac;
reg        user_flag_a;
reg        user_flag_b;
reg        bs;
reg        mb;
reg [2:0]  sp;
reg        irq_en;
reg        tirq_en;
reg        in_isr;
reg        tf;
reg        tpend;
reg        trun;
reg        crun;
reg        tb_prev;
reg [7:0]  timer;
reg [4:0]  pre;
reg [1:0]  div;
reg        run_reg;
reg        cond;
reg [7:0]  ram [0:`RAM_WORDS-1];

wire [7:0] program_status_word = {cy, ac, user_flag_a, bs, 1'b1, sp};
wire [5:0] sadr = `STACK_BASE + {2'h0, sp, 1'b0};
wire [5:0] padr = `STACK_BASE + {2'h0, sp - 3'h1, 1'b0};
wire [7:0] stk_lo = ram[padr];
wire [7:0] stk_hi = ram[padr + 6'h01];
wire [7:0] ptr = ram[wreg(bs, {2'h0, op[0]})];
wire [5:0] madr = op[3] ? ptr[5:0] : wreg(bs, op[2:0]);
wire [7:0] mval = ram[madr];
wire [7:0] src = (op[3:0] == `SRC_IMM) ? arg : mval;
wire       cin = (op[7:4] == `G_ADDC) & cy;
wire [8:0] sum = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
wire [4:0] nsum = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
wire [8:0] da1 = (acc[3:0] > `DA_LIM || ac) ?
	({1'b0, acc} + `DA_LO_FIX) : {1'b0, acc};
wire       da_hi = (da1[7:4] > `DA_LIM) | cy | da1[8];
wire [8:0] da2 = da_hi ? (da1 + `DA_HI_FIX) : da1;
wire [7:0] dec_r = mval - 8'h01;
wire [1:0] xcmd = {op[3], op[3] ^ op[2]};
wire       tick = (trun & (pre == `TMR_PRESCALE)) |
	(crun & tb_prev & ~test_input_b);

// ----------------------------------------------------------------------
// branch condition, sampled live during execute
// ----------------------------------------------------------------------
always @*
begin
	cond = 1'b0;
	case (op)
	`OP_JC:   cond = cy;
	`OP_JNC:  cond = ~cy;
	`OP_JZ:   cond = (acc == 8'h00);
	`OP_JNZ:  cond = (acc != 8'h00);
	`OP_JTA:  cond = test_input_a;
	`OP_JNTA: cond = ~test_input_a;
	`OP_JTB:  cond = test_input_b;
	`OP_JNTB: cond = ~test_input_b;
	`OP_JFA:  cond = user_flag_a;
	`OP_JFB:  cond = user_flag_b;
	`OP_JTF:  cond = tf;
	`OP_JNI:  cond = ~ext_irq_n;
	default:
		if (op[7:3] == {`G_DJNZ, 1'b0})
			cond = (dec_r != 8'h00);
		else if (op[7:3] == {`G_JCND, 1'b1})
			cond = acc[op[2:0]];
	endcase
end

// ----------------------------------------------------------------------
// apb slave
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata  <= 32'h00000000;
		pready  <= 1'b0;
		pslverr <= 1'b0;
		run_reg <= `CTRL_RST;
	end
	else if (psel && !penable)
	begin
		pready  <= 1'b1;
		pslverr <= (paddr != `CTRL_OFS) && (paddr != `STAT_OFS);
		if (paddr == `STAT_OFS)
			prdata <= {4'h0, pc, program_status_word, acc};
		else if (paddr == `CTRL_OFS)
			prdata <= {31'h00000000, run_reg};
		else
			prdata <= 32'h00000000;
	end
	else
	begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		if (psel && penable && pready && pwrite && paddr == `CTRL_OFS)
			run_reg <= pwdata[`CTRL_RUN_BIT];
	end
end

// ----------------------------------------------------------------------
// core sequencer
// ----------------------------------------------------------------------
task push;
	input [11:0] ret;
	begin
		ram[sadr] <= ret[7:0];
		ram[sadr + 6'h01] <= {program_status_word[7:4], ret[11:8]};
		sp <= sp + 3'h1;
	end
endtask

task set_p1;
	input [7:0] v;
	begin
		p1_out <= v;
		p1_oe  <= ~v;
	end
endtask

task set_p2;
	input [7:0] v;
	begin
		p2_out <= v;
		p2_oe  <= ~v;
	end
endtask

always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		state <= S_FETCH;
		op <= 8'h00;
		arg <= 8'h00;
		acc <= 8'h00;
		pc <= 12'h000;
		{cy, ac, user_flag_a, user_flag_b, bs, mb} <= 6'h00;
		sp <= 3'h0;
		{irq_en, tirq_en, in_isr, tf, tpend, trun, crun} <= 7'h00;
		tb_prev <= 1'b0;
		timer <= 8'h00;
		pre <= 5'h00;
		div <= 2'h0;
		prog_addr <= 12'h000;
		test_a_clk_out <= 1'b0;
		test_a_clk_oe <= 1'b0;
		p1_out <= 8'hFF;
		p1_oe <= 8'h00;
		p2_out <= 8'hFF;
		p2_oe <= 8'h00;
		bus_out <= 8'h00;
		bus_oe <= 1'b0;
		bus_ale <= 1'b0;
		bus_rd_n <= 1'b1;
		bus_wr_n <= 1'b1;
		exp_strobe_n <= 1'b1;
	end
	else
	begin
		tb_prev <= test_input_b;
		div <= (div == `CLK_DIV_LAST) ? 2'h0 : div + 2'h1;
		test_a_clk_out <= test_a_clk_oe & (div == 2'h0);
		if (trun)
			pre <= pre + 5'h01;
		if (tick)
			timer <= timer + 8'h01;
		case (state)
		S_FETCH:
			if (run_reg)
			begin
				if (irq_en && !ext_irq_n && !in_isr)
				begin
					push(pc);
					pc <= `VEC_EXT;
					in_isr <= 1'b1;
				end
				else if (tirq_en && tpend && !in_isr)
				begin
					push(pc);
					pc <= `VEC_TMR;
					in_isr <= 1'b1;
					tpend <= 1'b0;
				end
				else
				begin
					prog_addr <= pc;
					state <= S_OP;
				end
			end
		S_OP:
		begin
			op <= prog_data;
			pc <= inc_pc(pc);
			prog_addr <= inc_pc(pc);
			state <= two_byte(prog_data) ? S_ARG : S_EXEC;
		end
		S_ARG:
		begin
			arg <= prog_data;
			pc <= inc_pc(pc);
			state <= S_EXEC;
		end
		S_EXEC:
		begin
			state <= S_FETCH;
			if (cond)
				pc <= {pc[11:8], arg};
			case (op[7:4])
			`G_MISC0, `G_MISC1, `G_MISC2:
				case (op)
				`OP_INCA: acc <= acc + 8'h01;
				`OP_DECA: acc <= acc - 8'h01;
				`OP_CLRA: acc <= 8'h00;
				`OP_CPLA: acc <= ~acc;
				`OP_DAA:
				begin
					acc <= da2[7:0];
					cy <= da_hi;
				end
				`OP_SWAP: acc <= {acc[3:0], acc[7:4]};
				`OP_RL:   acc <= {acc[6:0], acc[7]};
				`OP_RLC:
				begin
					acc <= {acc[6:0], cy};
					cy <= acc[7];
				end
				`OP_RR:   acc <= {acc[0], acc[7:1]};
				`OP_RRC:
				begin
					acc <= {cy, acc[7:1]};
					cy <= acc[0];
				end
				`OP_CLRC:  cy <= 1'b0;
				`OP_CPLC:  cy <= ~cy;
				`OP_CLRFA: user_flag_a <= 1'b0;
				`OP_CPLFA: user_flag_a <= ~user_flag_a;
				`OP_CLRFB: user_flag_b <= 1'b0;
				`OP_CPLFB: user_flag_b <= ~user_flag_b;
				`OP_ENI:   irq_en <= 1'b1;
				`OP_DISI:  irq_en <= 1'b0;
				`OP_ENTI:  tirq_en <= 1'b1;
				`OP_DISTI: tirq_en <= 1'b0;
				`OP_STRT:  {trun, crun} <= 2'h2;
				`OP_STRTC: {trun, crun} <= 2'h1;
				`OP_STOP:  {trun, crun} <= 2'h0;
				`OP_ENCLK: test_a_clk_oe <= 1'b1;
				`OP_MB0:   mb <= 1'b0;
				`OP_MB1:   mb <= 1'b1;
				`OP_RB0:   bs <= 1'b0;
				`OP_RB1:   bs <= 1'b1;
				`OP_MOVAT: acc <= timer;
				`OP_MOVTA: timer <= acc;
				`OP_RDSTAT: acc <= program_status_word;
				`OP_WRSTAT:
				begin
					{cy, ac, user_flag_a, bs} <= acc[7:4];
					sp <= acc[2:0];
				end
				`OP_RET, `OP_RETR:
				begin
					pc <= {stk_hi[3:0], stk_lo};
					sp <= sp - 3'h1;
					if (op == `OP_RETR)
					begin
						{cy, ac, user_flag_a, bs} <= stk_hi[7:4];
						in_isr <= 1'b0;
					end
				end
				`OP_JMPP:
				begin
					prog_addr <= {pc[11:8], acc};
					state <= S_TBL;
				end
				`OP_OUTBUS:
				begin
					bus_out <= acc;
					bus_oe <= 1'b1;
				end
				`OP_INSBUS: acc <= bus_in;
				`OP_XRDA, `OP_XRDB, `OP_XWRA, `OP_XWRB:
				begin
					bus_out <= ptr;
					bus_oe <= 1'b1;
					bus_ale <= 1'b1;
					state <= S_EXT1;
				end
				`OP_INP1:  acc <= p1_in;
				`OP_INP2:  acc <= p2_in;
				`OP_OUTP1: set_p1(acc);
				`OP_OUTP2: set_p2(acc);
				default: ;
				endcase
			`G_JMP:
			begin
				pc <= {mb, op[2:0], arg};
				if (op[3])
					push(pc);
			end
			`G_ADD, `G_ADDC:
			begin
				acc <= sum[7:0];
				cy <= sum[8];
				ac <= nsum[4];
			end
			`G_ANL:  acc <= acc & src;
			`G_ORL:  acc <= acc | src;
			`G_XRL:  acc <= acc ^ src;
			`G_MOVA: acc <= src;
			`G_MOVM: ram[madr] <= acc;
			`G_INC:  ram[madr] <= mval + 8'h01;
			`G_XCH:
				case (op)
				`OP_XCHDA, `OP_XCHDB:
				begin
					acc <= {acc[7:4], mval[3:0]};
					ram[madr] <= {mval[7:4], acc[3:0]};
				end
				`OP_ANLP1: set_p1(p1_out & arg);
				`OP_ANLP2: set_p2(p2_out & arg);
				`OP_ORLP1: set_p1(p1_out | arg);
				`OP_ORLP2: set_p2(p2_out | arg);
				default:
				begin
					acc <= mval;
					ram[madr] <= acc;
				end
				endcase
			`G_DJNZ:
				if (!op[3])
					ram[madr] <= dec_r;
				else if (op == `OP_ANLB)
					bus_out <= bus_out & arg;
				else if (op == `OP_ORLB)
					bus_out <= bus_out | arg;
				else if (op == `OP_JTF)
					tf <= 1'b0;
			`G_EXP:
			begin
				set_p2({p2_out[7:4], xcmd, op[1:0]});
				state <= S_XP1;
			end
			default: ;
			endcase
		end
		S_TBL:
		begin
			pc <= {pc[11:8], prog_data};
			state <= S_FETCH;
		end
		S_EXT1:
		begin
			bus_ale <= 1'b0;
			if (op[3])
			begin
				bus_out <= acc;
				bus_wr_n <= 1'b0;
			end
			else
			begin
				bus_oe <= 1'b0;
				bus_rd_n <= 1'b0;
			end
			state <= S_EXT2;
		end
		S_EXT2:
		begin
			if (!bus_rd_n)
				acc <= bus_in;
			bus_rd_n <= 1'b1;
			bus_wr_n <= 1'b1;
			bus_oe <= 1'b0;
			state <= S_FETCH;
		end
		S_XP1:
		begin
			exp_strobe_n <= 1'b0;
			if (op[3:2] == 2'h0)
				set_p2({p2_out[7:4], 4'hF});
			else if (op[3:2] == 2'h1)
				set_p2({p2_out[7:4], acc[3:0]});
			else
				set_p2({p2_out[7:4], acc[3:0]});
			state <= S_XP2;
		end
		S_XP2:
		begin
			exp_strobe_n <= 1'b1;
			if (op[3:2] == 2'h0)
				acc <= {4'h0, p2_in[3:0]};
			state <= S_FETCH;
		end
		default: state <= S_FETCH;
		endcase
		if (tick && timer == 8'hFF)
		begin
			tf <= 1'b1;
			tpend <= 1'b1;
		end
	end
end

endmodule // mcu8_core

// ### hw/mcu8_core_regs.vh
// offsets, field positions, timing counts and opcode map of the mcu core
`ifndef MCU8_CORE_REGS_VH
`define MCU8_CORE_REGS_VH
// ----------------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------------
`define CTRL_OFS      8'h00
`define STAT_OFS      8'h04
`define CTRL_RUN_BIT  0
`define CTRL_RST      1'h1
// ----------------------------------------------------------------------
// memory layout and timing
// ----------------------------------------------------------------------
`define RAM_WORDS     64
`define STACK_BASE    6'h08
`define BANK1_BASE    6'h18
`define VEC_EXT       12'h003
`define VEC_TMR       12'h007
`define TMR_PRESCALE  5'h1F
`define CLK_DIV_LAST  2'h2
`define DA_LIM        4'h9
`define DA_LO_FIX     9'h006
`define DA_HI_FIX     9'h060
`define SRC_IMM       4'hA
// ----------------------------------------------------------------------
// opcode groups (upper nibble)
// ----------------------------------------------------------------------
`define G_MISC0  4'h0
`define G_MISC1  4'h1
`define G_MISC2  4'h2
`define G_JMP    4'h3
`define G_ADD    4'h4
`define G_ADDC   4'h5
`define G_ANL    4'h6
`define G_ORL    4'h7
`define G_XRL    4'h8
`define G_MOVA   4'h9
`define G_MOVM   4'hA
`define G_INC    4'hB
`define G_XCH    4'hC
`define G_DJNZ   4'hD
`define G_EXP    4'hE
`define G_JCND   4'hF
// ----------------------------------------------------------------------
// single opcodes
// ----------------------------------------------------------------------
`define OP_INCA    8'h01
`define OP_DECA    8'h02
`define OP_CLRA    8'h03
`define OP_CPLA    8'h04
`define OP_DAA     8'h05
`define OP_SWAP    8'h06
`define OP_RL      8'h07
`define OP_RLC     8'h08
`define OP_RR      8'h09
`define OP_RRC     8'h0A
`define OP_CLRC    8'h0B
`define OP_CPLC    8'h0C
`define OP_CLRFA   8'h0D
`define OP_CPLFA   8'h0E
`define OP_CLRFB   8'h0F
`define OP_CPLFB   8'h10
`define OP_ENI     8'h11
`define OP_DISI    8'h12
`define OP_ENTI    8'h13
`define OP_DISTI   8'h14
`define OP_STRT    8'h15
`define OP_STRTC   8'h16
`define OP_STOP    8'h17
`define OP_ENCLK   8'h18
`define OP_MB0     8'h19
`define OP_MB1     8'h1A
`define OP_RB0     8'h1B
`define OP_RB1     8'h1C
`define OP_MOVAT   8'h1D
`define OP_MOVTA   8'h1E
`define OP_RDSTAT  8'h1F
`define OP_WRSTAT  8'h20
`define OP_RET     8'h21
`define OP_RETR    8'h22
`define OP_JMPP    8'h23
`define OP_OUTBUS  8'h24
`define OP_INSBUS  8'h25
`define OP_XRDA    8'h26
`define OP_XRDB    8'h27
`define OP_XWRA    8'h28
`define OP_XWRB    8'h29
`define OP_INP1    8'h2A
`define OP_INP2    8'h2B
`define OP_OUTP1   8'h2C
`define OP_OUTP2   8'h2D
`define OP_XCHDA   8'hCA
`define OP_XCHDB   8'hCB
`define OP_ANLP1   8'hCC
`define OP_ANLP2   8'hCD
`define OP_ORLP1   8'hCE
`define OP_ORLP2   8'hCF
`define OP_ANLB    8'hD8
`define OP_ORLB    8'hD9
`define OP_JFA     8'hDA
`define OP_JFB     8'hDB
`define OP_JTF     8'hDC
`define OP_JNI     8'hDD
`define OP_JC      8'hF0
`define OP_JNC     8'hF1
`define OP_JZ      8'hF2
`define OP_JNZ     8'hF3
`define OP_JTA     8'hF4
`define OP_JNTA    8'hF5
`define OP_JTB     8'hF6
`define OP_JNTB    8'hF7
`endif

// ### tb/mcu8_core_asserts.sv
// concurrent checks on the ports of the mcu core
`include "mcu8_core_regs.vh"
module mcu8_core_asserts (
	input logic       pclk,
	input logic       presetn,
	input logic [7:0] paddr,
	input logic       psel,
	input logic       penable,
	input logic       pready,
	input logic       pslverr,
	input logic       bus_oe,
	input logic       bus_ale,
	input logic       bus_rd_n,
	input logic       bus_wr_n,
	input logic [7:0] p1_out,
	input logic [7:0] p1_oe,
	input logic [7:0] p2_out,
	input logic [7:0] p2_oe,
	input logic       test_a_clk_out,
	input logic       test_a_clk_oe,
	input logic       exp_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------------
	sequence s_one_strobe;
		bus_rd_n ^ bus_wr_n;
	endsequence
	sequence s_released;
		bus_rd_n && bus_wr_n && !bus_oe;
	endsequence
	sequence s_div_gap;
		!test_a_clk_out ##1 !test_a_clk_out ##1 test_a_clk_out;
	endsequence
	// ------------------------------------------------------------------
	// properties
	// ------------------------------------------------------------------
	property p_apb_ready;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	property p_apb_err;
		pready && pslverr |-> paddr != `CTRL_OFS && paddr != `STAT_OFS;
	endproperty
	property p_ext_move;
		bus_ale |=> s_one_strobe ##1 s_released;
	endproperty
	property p_rd_hiz;
		!bus_rd_n |-> !bus_oe;
	endproperty
	property p_wr_drive;
		!bus_wr_n |-> bus_oe && !bus_ale;
	endproperty
	property p_bus_hold;
		$fell(bus_oe) |-> $past(bus_ale) || !$past(bus_wr_n)
			|| !$past(presetn);
	endproperty
	property p_port_oe;
		p1_oe == ~p1_out;
	endproperty
	property p_port2_oe;
		p2_oe == ~p2_out;
	endproperty
	property p_clk_div3;
		test_a_clk_out |=> s_div_gap;
	endproperty
	property p_clk_kept;
		test_a_clk_oe |=> test_a_clk_oe;
	endproperty
	property p_exp_pulse;
		$fell(exp_strobe_n) |=> exp_strobe_n;
	endproperty
	a_apb_ready: assert property (p_apb_ready)
		else $error("pready not one cycle after setup");
	a_apb_err: assert property (p_apb_err)
		else $error("error answer on a mapped address");
	a_ext_move: assert property (p_ext_move)
		else $error("bad strobe sequence after address latch");
	a_rd_hiz: assert property (p_rd_hiz)
		else $error("bus driven during read strobe");
	a_wr_drive: assert property (p_wr_drive)
		else $error("bus not driven during write strobe");
	a_bus_hold: assert property (p_bus_hold)
		else $error("bus output dropped without external move");
	a_port_oe: assert property (p_port_oe)
		else $error("port drive does not follow latch");
	a_port2_oe: assert property (p_port2_oe)
		else $error("port 2 drive does not follow latch");
	a_clk_div3: assert property (p_clk_div3)
		else $error("clock output not divided by three");
	a_clk_kept: assert property (p_clk_kept)
		else $error("clock output cancelled without reset");
	a_exp_pulse: assert property (p_exp_pulse)
		else $error("expander strobe longer than one cycle");
endmodule // mcu8_core_asserts

// ### tb/mcu8_far_side.sv
// model of program memory, external data memory, expander and port pins
module mcu8_far_side (
	input  logic [11:0] prog_addr,
	output logic [7:0]  prog_data,
	input  logic        pclk,
	input  logic [7:0]  bus_out,
	input  logic        bus_oe,
	input  logic        bus_ale,
	input  logic        bus_rd_n,
	input  logic        bus_wr_n,
	output logic [7:0]  bus_in,
	input  logic [7:0]  p1_out,
	input  logic [7:0]  p2_out,
	input  logic        exp_strobe_n,
	input  logic [7:0]  ext_p1,
	output logic [7:0]  p1_in,
	output logic [7:0]  p2_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rom [4096];
	logic [7:0] xmem [256];
	logic [7:0] addr_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic [3:0] cmd_q  = 4'h0;
	logic [3:0] xp [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
	assign prog_data = rom[prog_addr];
	always @(posedge pclk)
	begin
		if (bus_ale)
			addr_q <= bus_out;
		if (!bus_wr_n)
			xmem[addr_q] <= bus_out;
		if (bus_oe)
			last_q <= bus_out;
		if (exp_strobe_n)
			cmd_q <= p2_out[3:0];
		else if (cmd_q[3:2] == 2'b01)
			xp[cmd_q[1:0]] <= p2_out[3:0];
		else if (cmd_q[3:2] == 2'b11)
			xp[cmd_q[1:0]] <= xp[cmd_q[1:0]] & p2_out[3:0];
		else if (cmd_q[3:2] == 2'b10)
			xp[cmd_q[1:0]] <= xp[cmd_q[1:0]] | p2_out[3:0];
	end
	// a released bus shows the inverse of its last driven value
	assign bus_in = !bus_rd_n ? xmem[addr_q] : ~last_q;
	// quasi pins: a zero in the latch pulls the pin low
	assign p1_in = p1_out & ext_p1;
	assign p2_in[7:4] = p2_out[7:4];
	assign p2_in[3:0] = (!exp_strobe_n && cmd_q[3:2] == 2'b00) ?
		xp[cmd_q[1:0]] & p2_out[3:0] : p2_out[3:0];
endmodule // mcu8_far_side

// ### tb/test_mcu8_instruction_semantics.sv
// self-checking bench of the mcu core against a reference model
`include "mcu8_core_regs.vh"
module test_mcu8_instruction_semantics;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  ext_p1 = 8'hFF;
	logic        test_input_a = 1'b0, test_input_b = 1'b0, ext_irq_n = 1'b1;
	logic [31:0] prdata, q, r, seed = 32'd97238;
	logic        pready, pslverr, e, c, test_a_clk_out, test_a_clk_oe;
	logic [11:0] prog_addr;
	logic [7:0]  prog_data, p1_in, p1_out, p1_oe, p2_in, p2_out, p2_oe;
	logic [7:0]  bus_in, bus_out, op, a, b;
	logic        bus_oe, bus_ale, bus_rd_n, bus_wr_n, exp_strobe_n;
	logic [8:0]  x;
	int          error_cnt = 0, total_checks = 0, cyc = 0, n;
	logic [7:0]  ops [15] = '{8'h4A, 8'h5A, 8'h6A, 8'h7A, 8'h8A, `OP_INCA,
		`OP_DECA, `OP_CLRA, `OP_CPLA, `OP_SWAP, `OP_RL, `OP_RLC, `OP_RR,
		`OP_RRC, `OP_DAA};
	always #20 pclk = ~pclk;
	mcu8_core DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .prog_addr, .prog_data,
		.test_input_a, .test_input_b, .ext_irq_n,
		.test_a_clk_out, .test_a_clk_oe, .p1_in, .p1_out, .p1_oe, .p2_in,
		.p2_out, .p2_oe, .bus_in, .bus_out, .bus_oe, .bus_ale, .bus_rd_n,
		.bus_wr_n, .exp_strobe_n);
	mcu8_far_side far (.prog_addr, .prog_data, .pclk, .bus_out, .bus_oe,
		.bus_ale, .bus_rd_n, .bus_wr_n, .bus_in, .p1_out, .p2_out,
		.exp_strobe_n, .ext_p1, .p1_in, .p2_in);
	// ------------------------------------------------------------------
	// model, compare and bus tasks
	// ------------------------------------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] bcd(input logic [7:0] v);
		return {v[7:4] % 4'hA, v[3:0] % 4'hA};
	endfunction
	// returns {carry, accumulator}
	function automatic logic [8:0] alu(input logic [7:0] o, s, d,
		input logic ci);
		logic [8:0] t;
		logic       h;
		t = {ci, s};
		case (o)
		8'h4A: t = s + d;
		8'h5A: t = s + d + ci;
		8'h6A: t[7:0] = s & d;
		8'h7A: t[7:0] = s | d;
		8'h8A: t[7:0] = s ^ d;
		`OP_INCA: t[7:0] = s + 8'h01;
		`OP_DECA: t[7:0] = s - 8'h01;
		`OP_CLRA: t[7:0] = 8'h00;
		`OP_CPLA: t[7:0] = ~s;
		`OP_SWAP: t[7:0] = {s[3:0], s[7:4]};
		`OP_RL: t[7:0] = {s[6:0], s[7]};
		`OP_RLC: t = {s, ci};
		`OP_RR: t[7:0] = {s[0], s[7:1]};
		`OP_RRC: t = {s[0], ci, s[7:1]};
		default:
		begin
			t = s + d;
			if (t[3:0] > 4'h9 || s[3:0] + d[3:0] > 5'h0F)
				t = t + 9'h006;
			h = t[8] || t[7:4] > 4'h9;
			t = {h, t[7:0] + (h ? 8'h60 : 8'h00)};
		end
		endcase
		return t;
	endfunction
	task close_out;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= ad;
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		chk(pready, 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task load(input logic [63:0] code);
		int i;
		for (i = 0; i < 4096; i++)
			far.rom[i] = 8'h00;
		for (i = 0; i < 8; i++)
			far.rom[i] = code[63 - 8 * i -: 8];
	endtask
	// restart from address zero, run, then read the status word
	task go;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(test_a_clk_oe, 1'b0);
		repeat (45) @(posedge pclk);
		apb(1'b0, `STAT_OFS, 32'h0);
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			$display("ERROR %0t run did not finish", $time);
			close_out;
		end
	end
	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CTRL_OFS, 32'h0);
		chk(q, {31'h0, `CTRL_RST});
		apb(1'b1, `CTRL_OFS, 32'h0);
		apb(1'b0, `CTRL_OFS, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, `CTRL_OFS, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0);
		for (n = 0; n < 30; n++)
		begin
			r = rnd();
			op = ops[n % 15];
			c = r[24];
			a = op == `OP_DAA ? bcd(r[15:8]) : r[15:8];
			b = op == `OP_DAA ? bcd(r[23:16]) : r[23:16];
			x = alu(op, a, b, c);
			load({8'h0B, c ? `OP_CPLC : 8'h00, 8'h9A, a,
				op == `OP_DAA ? 8'h4A : op,
				op[7:4] != 4'h0 || op == `OP_DAA ? b : 8'h00,
				op == `OP_DAA ? `OP_DAA : 8'h00, 8'h00});
			go;
			chk(q[7:0], x[7:0]);
			chk(q[15], x[8]);
		end
		load(64'h9AA52CCC0F000000);
		go;
		chk({p1_out, p1_oe}, 16'h05FA);
		r = rnd();
		ext_p1 <= r[7:0];
		load(64'h2A00000000000000);
		go;
		chk(q[7:0], r[7:0]);
		load(64'h9A3CA0289A002600);
		go;
		chk({bus_oe, q[7:0]}, 9'h03C);
		load(64'h9A77240000000000);
		go;
		chk({bus_oe, bus_out}, 9'h177);
		load(64'h9A0BE69A00E20000);
		go;
		chk(q[3:0], 4'hB);
		load(64'h9A421E9A001D0000);
		go;
		chk(q[7:0], 8'h42);
		load(64'h0E1C1A0000000000);
		go;
		chk({q[27], q[13:11]}, 4'h7);
		load(64'h9A10230000000000);
		far.rom[16] = 8'h40;
		far.rom[64] = 8'h9A;
		far.rom[65] = 8'h5A;
		go;
		chk(q[7:0], 8'h5A);
		for (n = 0; n < 2; n++)
		begin
			r = rnd();
			test_input_a <= r[0];
			test_input_b <= r[1];
			load({n ? `OP_JTB : `OP_JTA, 56'h069A1100000000});
			go;
			chk(q[7:0], r[n] ? 8'h00 : 8'h11);
		end
		ext_irq_n <= 1'b0;
		load({`OP_ENI, 56'h0});
		go;
		chk(q[10:8], 3'h1);
		ext_irq_n <= 1'b1;
		load({`OP_ENCLK, 56'h0});
		go;
		chk(test_a_clk_oe, 1'b1);
		go;
		close_out;
	end
endmodule // test_mcu8_instruction_semantics

bind mcu8_core mcu8_core_asserts u_chk (.pclk, .presetn, .paddr, .psel,
	.penable, .pready, .pslverr, .bus_oe, .bus_ale, .bus_rd_n, .bus_wr_n,
	.p1_out, .p1_oe, .p2_out, .p2_oe, .test_a_clk_out, .test_a_clk_oe,
	.exp_strobe_n);
